// ---- hw/pll_cgm_pkg.sv ----
// Constants, register map and carrier types of the PLL clock control block.
// Assumes a single 20 MHz bus clock and an AXI4-Lite master with 8-bit addr.
`default_nettype none

package pll_cgm_pkg;

    // Byte offsets of the three registers
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BW   = 8'h04;
    localparam logic [7:0] OFS_PROG = 8'h08;

    // PLL control register fields
    localparam int CTRL_IE_BIT   = 7;
    localparam int CTRL_FLAG_BIT = 6;
    localparam int CTRL_ON_BIT   = 5;
    localparam int CTRL_BCS_BIT  = 4;
    localparam logic [3:0] CTRL_UNUSED_VAL = 4'hF;

    // Bandwidth control register fields
    localparam int BW_AUTO_BIT = 7;
    localparam int BW_LOCK_BIT = 6;
    localparam int BW_ACQ_BIT  = 5;
    localparam int BW_XLD_BIT  = 4;
    localparam logic [3:0] BW_TEST_VAL = 4'h0;

    // Programming register fields
    localparam int PROG_N_LSB = 4;
    localparam int PROG_L_LSB = 0;

    // Reset values
    localparam logic       RST_ON  = 1'b1;
    localparam logic [3:0] RST_N   = 4'h6;
    localparam logic [3:0] RST_L   = 4'h6;
    localparam logic [3:0] N_MIN   = 4'h1;

    // Source edges awaited on each clock during a source change
    localparam logic [1:0] SWITCH_EDGES = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } axil_m2s_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_s2m_t;

    // Status from the analog loop, asynchronous to the bus clock
    typedef struct packed {
        logic lock;
        logic acq;
    } analog_t;

    typedef enum logic [1:0] {
        SW_IDLE = 2'b01,
        SW_WAIT = 2'b10
    } sw_state_t;

endpackage : pll_cgm_pkg

`default_nettype wire

// ---- hw/pll_clock_generator_control.sv ----
// PLL clock generator control: registers, lock flag, base clock selection.
// Assumes clocks and analog status arrive asynchronously on pins and that
// stop_in and oscillator_enable_in come from logic on aclk.
//
// Summary of operation
// - Lock interrupt enable gates requests; ignored and reads zero in manual.
// - Lock change flag sets on each lock toggle in automatic mode; with enable drives irq.
// - Lock change flag reads zero while automatic mode is off.
// - A read of the control register clears the flag unless a lock edge comes in the same cycle; reset clears.
// - Power-on bit enables the PLL; reset sets it.
// - Power-on cannot be cleared while base clock select is set.
// - Base clock is the selected source divided by two, 50% duty.
// - Base clock select cannot be set while power-on is clear.
// - Source change waits three edges of each clock; output held.
// - Reset and stop clear base clock select.
// - Low four control bits ignore writes and read as ones.
// - Mode bit selects automatic or manual bandwidth; reset gives manual.
// - Lock bit shows lock in automatic mode, zero in manual.
// - Filter mode writable in manual, status in automatic; reset zero.
// - Manual filter mode value is kept and restored after automatic.
// - Crystal-loss bit written one reads back one if crystal is dead.
// - Crystal-loss check works only with select set; else reads zero.
// - Multiplier field sets N, code zero acts as one; reset six.
// - Multiplier and range writes ignored while power-on is set.
// - Range zero disables PLL and clears and blocks select; reset six.
// - Programming register holds N high nibble and L low nibble.
// - Stop disables the generator and drives clock and irq outputs low.
`default_nettype none

module pll_clock_generator_control (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Register bus
    input  wire pll_cgm_pkg::axil_m2s_t bus_in,
    output var  pll_cgm_pkg::axil_s2m_t bus_out,
    // Clock sources and analog status
    input  wire logic                  crystal_clock,
    input  wire logic                  vco_clock,
    input  wire pll_cgm_pkg::analog_t  analog_in,
    // System control
    input  wire logic                  oscillator_enable_in,
    input  wire logic                  stop_in,
    // Clock and interrupt outputs
    output logic                       base_clock_out,
    output logic                       crystal_clock_out,
    output logic                       pll_irq_line,
    // Analog loop control
    output logic                       pll_enable_out,
    output logic [3:0]                 feedback_factor_n_out,
    output logic [3:0]                 vco_range_factor_out,
    output logic                       filter_tracking_out,
    output logic                       auto_mode_out
);
    import pll_cgm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers: {crystal, vco, lock, acq}

    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] prev_r;
    logic       xtal_rise;
    logic       vco_rise;
    logic       lock_s;
    logic       acq_s;
    logic       lock_edge;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            prev_r  <= 4'h0;
        end else begin
            sync1_r <= {crystal_clock, vco_clock, analog_in.lock,
                        analog_in.acq};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    assign xtal_rise = sync2_r[3] & ~prev_r[3];
    assign vco_rise  = sync2_r[2] & ~prev_r[2];
    assign lock_s    = sync2_r[1];
    assign acq_s     = sync2_r[0];

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    axil_s2m_t   s2m_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  waddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_fire;
    logic        rd_take;
    logic        rd_ctrl;
    logic        wr_ctrl;
    logic        wr_bw;
    logic        wr_prog;
    logic        w_hit;
    logic        r_hit;
    logic [7:0]  rd_byte;

    // Registers
    logic       ie_r;
    logic       flag_r;
    logic       on_r;
    logic       bcs_r;
    logic       auto_r;
    logic       acq_man_r;
    logic       xld_r;
    logic [3:0] n_r;
    logic [3:0] l_r;

    assign wr_fire = aw_held_r & w_held_r & ~s2m_r.bvalid;
    assign rd_take = s2m_r.arready & bus_in.arvalid;
    assign w_hit   = (waddr_r[7:2] == OFS_CTRL[7:2])
                   | (waddr_r[7:2] == OFS_BW[7:2])
                   | (waddr_r[7:2] == OFS_PROG[7:2]);
    assign r_hit   = (bus_in.araddr[7:2] == OFS_CTRL[7:2])
                   | (bus_in.araddr[7:2] == OFS_BW[7:2])
                   | (bus_in.araddr[7:2] == OFS_PROG[7:2]);
    // Only byte lane 0 carries register bits
    assign wr_ctrl = wr_fire & wstrb_r[0] & (waddr_r[7:2] == OFS_CTRL[7:2]);
    assign wr_bw   = wr_fire & wstrb_r[0] & (waddr_r[7:2] == OFS_BW[7:2]);
    assign wr_prog = wr_fire & wstrb_r[0] & (waddr_r[7:2] == OFS_PROG[7:2]);
    assign rd_ctrl = rd_take & (bus_in.araddr[7:2] == OFS_CTRL[7:2]);

    always_comb begin
        rd_byte = 8'h00;
        if (bus_in.araddr[7:2] == OFS_CTRL[7:2]) begin
            rd_byte = {ie_r & auto_r, flag_r & auto_r, on_r, bcs_r,
                       CTRL_UNUSED_VAL};
        end else if (bus_in.araddr[7:2] == OFS_BW[7:2]) begin
            rd_byte = {auto_r, auto_r & lock_s,
                       auto_r ? acq_s : acq_man_r,
                       bcs_r & xld_r, BW_TEST_VAL};
        end else if (bus_in.araddr[7:2] == OFS_PROG[7:2]) begin
            rd_byte = {n_r, l_r};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s2m_r     <= '0;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            waddr_r   <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (s2m_r.awready && bus_in.awvalid) begin
                waddr_r       <= bus_in.awaddr;
                aw_held_r     <= 1'b1;
                s2m_r.awready <= 1'b0;
            end else if (!aw_held_r && !s2m_r.bvalid) begin
                s2m_r.awready <= 1'b1;
            end
            if (s2m_r.wready && bus_in.wvalid) begin
                wdata_r      <= bus_in.wdata;
                wstrb_r      <= bus_in.wstrb;
                w_held_r     <= 1'b1;
                s2m_r.wready <= 1'b0;
            end else if (!w_held_r && !s2m_r.bvalid) begin
                s2m_r.wready <= 1'b1;
            end
            if (wr_fire) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s2m_r.bvalid <= 1'b1;
                s2m_r.bresp  <= w_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s2m_r.bvalid && bus_in.bready) begin
                s2m_r.bvalid <= 1'b0;
            end
            if (rd_take) begin
                s2m_r.arready <= 1'b0;
                s2m_r.rvalid  <= 1'b1;
                s2m_r.rdata   <= {24'h00_0000, rd_byte};
                s2m_r.rresp   <= r_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s2m_r.rvalid && bus_in.rready) begin
                s2m_r.rvalid  <= 1'b0;
            end else if (!s2m_r.rvalid) begin
                s2m_r.arready <= 1'b1;
            end
        end
    end

    assign bus_out = s2m_r;

    ////////////////////////////////////////////////////////////////////////
    // Control register

    assign lock_edge = auto_r & (lock_s != prev_r[1]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ie_r <= 1'b0;
        end else if (wr_ctrl && auto_r) begin
            ie_r <= wdata_r[CTRL_IE_BIT];
        end
    end

    // A new lock edge wins over the clearing read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= 1'b0;
        end else if (lock_edge) begin
            flag_r <= 1'b1;
        end else if (rd_ctrl) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_r <= RST_ON;
        end else if (wr_ctrl) begin
            on_r <= wdata_r[CTRL_ON_BIT] | bcs_r;
        end
    end

    // Pre-write power state is used, so selecting needs a second write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bcs_r <= 1'b0;
        end else if (stop_in) begin
            bcs_r <= 1'b0;
        end else if (l_r == 4'h0) begin
            bcs_r <= 1'b0;
        end else if (wr_ctrl) begin
            bcs_r <= wdata_r[CTRL_BCS_BIT] & on_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bandwidth control register

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_r <= 1'b0;
        end else if (wr_bw) begin
            auto_r <= wdata_r[BW_AUTO_BIT];
        end
    end

    // Holds the manual value through automatic mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acq_man_r <= 1'b0;
        end else if (wr_bw && !auto_r) begin
            acq_man_r <= wdata_r[BW_ACQ_BIT];
        end
    end

    // A software set wins; a crystal edge proves the reference alive
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xld_r <= 1'b0;
        end else if (!bcs_r) begin
            xld_r <= 1'b0;
        end else if (wr_bw && wdata_r[BW_XLD_BIT]) begin
            xld_r <= 1'b1;
        end else if (xtal_rise) begin
            xld_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Programming register

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            n_r <= RST_N;
            l_r <= RST_L;
        end else if (wr_prog && !on_r) begin
            n_r <= wdata_r[PROG_N_LSB +: 4];
            l_r <= wdata_r[PROG_L_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Base clock selector
    // Sources are sampled on aclk, so each must stay well below aclk / 4.

    sw_state_t  sw_state_r;
    logic       sel_r;
    logic [1:0] xcnt_r;
    logic [1:0] vcnt_r;
    logic       base_r;
    logic       src_rise;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_state_r <= SW_IDLE;
            sel_r      <= 1'b0;
            xcnt_r     <= 2'h0;
            vcnt_r     <= 2'h0;
        end else if (stop_in || l_r == 4'h0) begin
            // The VCO may be dead here, so do not wait on its edges
            sw_state_r <= SW_IDLE;
            sel_r      <= 1'b0;
            xcnt_r     <= 2'h0;
            vcnt_r     <= 2'h0;
        end else begin
            case (sw_state_r)
                SW_IDLE: begin
                    xcnt_r <= 2'h0;
                    vcnt_r <= 2'h0;
                    if (bcs_r != sel_r) begin
                        sw_state_r <= SW_WAIT;
                    end
                end
                SW_WAIT: begin
                    if (xtal_rise && xcnt_r != SWITCH_EDGES) begin
                        xcnt_r <= xcnt_r + 2'h1;
                    end
                    if (vco_rise && vcnt_r != SWITCH_EDGES) begin
                        vcnt_r <= vcnt_r + 2'h1;
                    end
                    if (xcnt_r == SWITCH_EDGES && vcnt_r == SWITCH_EDGES) begin
                        sel_r      <= bcs_r;
                        sw_state_r <= SW_IDLE;
                    end
                end
                default: begin
                    sw_state_r <= SW_IDLE;
                end
            endcase
        end
    end

    assign src_rise = sel_r ? vco_rise : xtal_rise;

    // Toggling once per source rise halves it with an even duty
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_r <= 1'b0;
        end else if (stop_in) begin
            base_r <= 1'b0;
        end else if (sw_state_r == SW_IDLE && bcs_r == sel_r && src_rise) begin
            base_r <= ~base_r;
        end
    end

    assign base_clock_out = base_r;

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crystal_clock_out     <= 1'b0;
            pll_irq_line          <= 1'b0;
            pll_enable_out        <= 1'b0;
            feedback_factor_n_out <= N_MIN;
            vco_range_factor_out  <= 4'h0;
            filter_tracking_out   <= 1'b0;
            auto_mode_out         <= 1'b0;
        end else begin
            crystal_clock_out <= sync2_r[3] & ~stop_in;
            pll_irq_line <= flag_r & ie_r & auto_r & ~stop_in;
            pll_enable_out <= on_r & (l_r != 4'h0)
                            & oscillator_enable_in & ~stop_in;
            feedback_factor_n_out <= (n_r == 4'h0) ? N_MIN : n_r;
            vco_range_factor_out  <= l_r;
            filter_tracking_out   <= auto_r ? acq_s : acq_man_r;
            auto_mode_out         <= auto_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_ie_manual;
        wr_ctrl && !auto_r |=> ie_r == $past(ie_r);
    endproperty
    a_ie_manual: assert property (p_ie_manual)
        else $error("enable changed in manual mode");

    property p_irq;
        lock_edge && ie_r && auto_r && !stop_in ##1 !stop_in |=> pll_irq_line;
    endproperty
    a_irq: assert property (p_irq)
        else $error("lock toggle raised no interrupt");

    property p_flag_manual;
        rd_ctrl && !auto_r |=> !bus_out.rdata[CTRL_FLAG_BIT];
    endproperty
    a_flag_manual: assert property (p_flag_manual)
        else $error("flag read as one in manual mode");

    property p_flag_clr;
        rd_ctrl && !lock_edge |=> !flag_r;
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("control read did not clear flag");

    property p_on_hold;
        wr_ctrl && bcs_r |=> on_r;
    endproperty
    a_on_hold: assert property (p_on_hold)
        else $error("power-on cleared while selected");

    property p_bcs_block;
        wr_ctrl && !on_r && !bcs_r |=> !bcs_r;
    endproperty
    a_bcs_block: assert property (p_bcs_block)
        else $error("select set while PLL off");

    property p_hold;
        sw_state_r == SW_WAIT && !stop_in |=> base_r == $past(base_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("base clock moved during switch");

    property p_stop;
        stop_in |=> !bcs_r && !base_clock_out && !crystal_clock_out
                    && !pll_irq_line;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop left outputs running");

    property p_ones;
        rd_ctrl |=> bus_out.rdata[3:0] == CTRL_UNUSED_VAL;
    endproperty
    a_ones: assert property (p_ones)
        else $error("unused control bits not ones");

    property p_prog_lock;
        wr_prog && on_r |=> n_r == $past(n_r) && l_r == $past(l_r);
    endproperty
    a_prog_lock: assert property (p_prog_lock)
        else $error("programming written while PLL on");

    property p_range0;
        l_r == 4'h0 |=> !bcs_r ##1 !pll_enable_out;
    endproperty
    a_range0: assert property (p_range0)
        else $error("range zero did not disable");

    property p_n_map;
        n_r == 4'h0 |=> feedback_factor_n_out == N_MIN;
    endproperty
    a_n_map: assert property (p_n_map)
        else $error("code zero not mapped to one");

endmodule : pll_clock_generator_control

`default_nettype wire

// ---- test/tb_pll_clock_generator_control.sv ----
// Self-checking bench for the PLL clock generator control block.
// Assumes pll_cgm_pkg is compiled first; source clocks come from counters.
`default_nettype none

module tb_pll_clock_generator_control;
    timeunit 1ns;
    timeprecision 1ns;
    import pll_cgm_pkg::*;

    logic       aclk, aresetn, crystal_clock, vco_clock, xtal_run;
    logic       oscillator_enable_in, stop_in;
    axil_m2s_t  bus_in;
    axil_s2m_t  bus_out;
    analog_t    analog_in;
    logic       base_clock_out, crystal_clock_out, pll_irq_line;
    logic       pll_enable_out, filter_tracking_out, auto_mode_out;
    logic [3:0] feedback_factor_n_out, vco_range_factor_out;
    int         n_fail, checks_done, cyc, xcnt, vcnt, n;
    logic [7:0] d;
    logic [1:0] r;

    pll_clock_generator_control i_dut (
        .aclk                  (aclk),
        .aresetn               (aresetn),
        .bus_in                (bus_in),
        .bus_out               (bus_out),
        .crystal_clock         (crystal_clock),
        .vco_clock             (vco_clock),
        .analog_in             (analog_in),
        .oscillator_enable_in  (oscillator_enable_in),
        .stop_in               (stop_in),
        .base_clock_out        (base_clock_out),
        .crystal_clock_out     (crystal_clock_out),
        .pll_irq_line          (pll_irq_line),
        .pll_enable_out        (pll_enable_out),
        .feedback_factor_n_out (feedback_factor_n_out),
        .vco_range_factor_out  (vco_range_factor_out),
        .filter_tracking_out   (filter_tracking_out),
        .auto_mode_out         (auto_mode_out)
    );

    always #25 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////
    // Sources well below aclk/4: crystal period 16 cycles, VCO period 10
    always @(posedge aclk) begin
        if (xcnt == 7) begin
            xcnt <= 0;
            if (xtal_run) crystal_clock <= ~crystal_clock;
        end else xcnt <= xcnt + 1;
        if (vcnt == 4) begin
            vcnt      <= 0;
            vco_clock <= ~vco_clock;
        end else vcnt <= vcnt + 1;
    end

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            n_fail++;
            $display("unexpected at %0t: run did not finish", $time);
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_n(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("unexpected at %0t: count %0d", $time, got);
        end
    endtask : chk_n

    // Both channels offered together; bready held until bvalid is seen
    task automatic wr(input logic [7:0] a, input logic [7:0] v,
                      output logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        bus_in.awvalid <= 1'b1;
        bus_in.awaddr  <= a;
        bus_in.wvalid  <= 1'b1;
        bus_in.wdata   <= {24'h000000, v};
        bus_in.wstrb   <= 4'hF;
        bus_in.bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (bus_in.awvalid && bus_out.awready === 1'b1) begin
                aw_ok = 1'b1;
                bus_in.awvalid <= 1'b0;
            end
            if (bus_in.wvalid && bus_out.wready === 1'b1) begin
                w_ok = 1'b1;
                bus_in.wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bus_out.bvalid !== 1'b1);
        resp = bus_out.bresp;
        bus_in.bready <= 1'b0;
        // One idle edge so a following call never re-raises bready at once
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v,
                      output logic [1:0] resp);
        bus_in.arvalid <= 1'b1;
        bus_in.araddr  <= a;
        bus_in.rready  <= 1'b1;
        do @(posedge aclk); while (bus_out.arready !== 1'b1);
        bus_in.arvalid <= 1'b0;
        do @(posedge aclk); while (bus_out.rvalid !== 1'b1);
        v    = bus_out.rdata[7:0];
        resp = bus_out.rresp;
        bus_in.rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic w(input logic [7:0] a, input logic [7:0] v);
        logic [1:0] rs;
        wr(a, v, rs);
        chk8({6'h00, rs}, {6'h00, RESP_OKAY});
    endtask : w

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        chk8(v, exp);
    endtask : rc

    // Rising edges of the base clock over a span of bus cycles
    task automatic count_rises(input int ncyc, output int cnt);
        logic prev;
        cnt  = 0;
        prev = base_clock_out;
        repeat (ncyc) begin
            @(posedge aclk);
            if (base_clock_out === 1'b1 && prev === 1'b0) cnt++;
            prev = base_clock_out;
        end
    endtask : count_rises

    ////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0; aresetn = 1'b0; crystal_clock = 1'b0; vco_clock = 1'b0;
        xtal_run = 1'b1; oscillator_enable_in = 1'b1; stop_in = 1'b0;
        bus_in = '0; analog_in = '0;
        n_fail = 0; checks_done = 0; cyc = 0; xcnt = 0; vcnt = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rc(OFS_CTRL, 8'h2F);
        rc(OFS_BW, 8'h00);
        rc(OFS_PROG, 8'h66);
        chk8({4'h0, feedback_factor_n_out}, 8'h06);
        chk8({7'h00, pll_enable_out}, 8'h01);
        rd(8'h0C, d, r);
        chk8({6'h00, r}, {6'h00, RESP_SLVERR});
        chk8(d, 8'h00);
        wr(8'h0C, 8'hFF, r);
        chk8({6'h00, r}, {6'h00, RESP_SLVERR});
        w(OFS_CTRL, 8'hFF);
        rc(OFS_CTRL, 8'h3F);
        w(OFS_CTRL, 8'h00);
        rc(OFS_CTRL, 8'h2F);
        w(OFS_CTRL, 8'h00);
        rc(OFS_CTRL, 8'h0F);
        chk8({7'h00, pll_enable_out}, 8'h00);
        w(OFS_CTRL, 8'h10);
        rc(OFS_CTRL, 8'h0F);
        w(OFS_PROG, 8'h0A);
        rc(OFS_PROG, 8'h0A);
        chk8({feedback_factor_n_out, vco_range_factor_out}, 8'h1A);
        w(OFS_PROG, 8'h60);
        w(OFS_CTRL, 8'h20);
        repeat (2) @(posedge aclk);
        chk8({7'h00, pll_enable_out}, 8'h00);
        w(OFS_CTRL, 8'h30);
        rc(OFS_CTRL, 8'h2F);
        w(OFS_PROG, 8'h33);
        rc(OFS_PROG, 8'h60);
        w(OFS_CTRL, 8'h00);
        w(OFS_PROG, 8'h66);
        w(OFS_CTRL, 8'h20);
        count_rises(320, n);
        chk_n(n, 9, 11);
        w(OFS_CTRL, 8'h30);
        count_rises(25, n);
        chk_n(n, 0, 0);
        repeat (80) @(posedge aclk);
        count_rises(400, n);
        chk_n(n, 19, 21);
        w(OFS_CTRL, 8'h10);
        rc(OFS_CTRL, 8'h3F);
        w(OFS_BW, 8'h10);
        repeat (40) @(posedge aclk);
        rc(OFS_BW, 8'h00);
        // A stopped crystal must be flagged while the VCO drives the output
        xtal_run <= 1'b0;
        repeat (20) @(posedge aclk);
        w(OFS_BW, 8'h10);
        repeat (40) @(posedge aclk);
        rc(OFS_BW, 8'h10);
        xtal_run <= 1'b1;
        stop_in  <= 1'b1;
        repeat (3) @(posedge aclk);
        chk8({4'h0, base_clock_out, crystal_clock_out, pll_irq_line,
              pll_enable_out}, 8'h00);
        rc(OFS_CTRL, 8'h2F);
        w(OFS_BW, 8'h10);
        rc(OFS_BW, 8'h00);
        stop_in <= 1'b0;
        w(OFS_BW, 8'h20);
        rc(OFS_BW, 8'h20);
        chk8({7'h00, filter_tracking_out}, 8'h01);
        w(OFS_BW, 8'hA0);
        rc(OFS_BW, 8'h80);
        chk8({6'h00, auto_mode_out, filter_tracking_out}, 8'h02);
        w(OFS_CTRL, 8'hA0);
        rc(OFS_CTRL, 8'hAF);
        analog_in.lock <= 1'b1;
        analog_in.acq  <= 1'b1;
        repeat (8) @(posedge aclk);
        chk8({7'h00, pll_irq_line}, 8'h01);
        rc(OFS_CTRL, 8'hEF);
        rc(OFS_CTRL, 8'hAF);
        chk8({7'h00, pll_irq_line}, 8'h00);
        rc(OFS_BW, 8'hE0);
        analog_in.lock <= 1'b0;
        repeat (8) @(posedge aclk);
        w(OFS_BW, 8'h00);
        repeat (2) @(posedge aclk);
        chk8({7'h00, pll_irq_line}, 8'h00);
        rc(OFS_CTRL, 8'h2F);
        rc(OFS_BW, 8'h20);
        conclude();
    end

endmodule : tb_pll_clock_generator_control

`default_nettype wire
